/* logic/gtw_params.svh */
`ifndef GTW_PARAMS_SVH
`define GTW_PARAMS_SVH
// Functional notes
// - Vector-table access wakes when watch bit set.
// - External input reloads timer or wakes, if enabled.
// - Debounce external input; width and polarity selectable.
// - Forced-entry write needs forced-entry enable bit.
// - Three-bit field selects idle period, resets 000.
// - Every wake-up reloads timer, asserts power enable.
// - Enabled low IRQ lines wake in power-save.
// - Enabled high IRQ lines wake in power-save.
// - In normal state IRQs only reload timer.
// - Timer expiry enters power-save when enabled.
// - Status bit reads 0 power-save, 1 normal.

// Register indexes; byte address is four times the index.
`define GTW_IDX_PEN 8'he0
`define GTW_IDX_CTL 8'he1
`define GTW_IDX_LOW 8'he2
`define GTW_IDX_HIGH 8'he3

// Control register fields.
`define GTW_CTL_VEC 7
`define GTW_CTL_RLD 6
`define GTW_CTL_WID 5
`define GTW_CTL_POL 4
`define GTW_CTL_FORCE 3
`define GTW_CTL_SEL_HI 2
`define GTW_CTL_SEL_LO 0

// Port-enable register fields.
`define GTW_PEN_FORCE_EN 0
`define GTW_PEN_TMR_EN 2
`define GTW_PEN_STATE 3

// Used bits of the interrupt enable registers.
`define GTW_LOW_MASK 8'hfa
`define GTW_HIGH_MASK 8'hdf
`define GTW_REG_RST 8'h00

// Timing, with cycle counts derived from the clock rate.
`define GTW_CLK_HZ 10000000
`define GTW_SHORT_NS 100
`define GTW_LONG_MS 5
`define GTW_SHORT_CYC ((`GTW_SHORT_NS * (`GTW_CLK_HZ / 1000000) + 999) / 1000)
`define GTW_LONG_CYC (`GTW_LONG_MS * (`GTW_CLK_HZ / 1000))
`define GTW_TICK_CYC (`GTW_CLK_HZ)

// Idle periods in seconds for each select code.
`define GTW_P0 14'd15
`define GTW_P1 14'd120
`define GTW_P2 14'd300
`define GTW_P3 14'd900
`define GTW_P4 14'd1800
`define GTW_P5 14'd2700
`define GTW_P6 14'd3600
`define GTW_P7 14'd14400
`endif

/* logic/gtw_pkg.sv */
package gtw_pkg;
	// Power state of the system as seen by the monitor.
	typedef enum logic {
		GTW_NORMAL,
		GTW_SAVE
	} gtw_state_e;
	// Idle period select code.
	typedef logic [2:0] gtw_sel_t;
endpackage : gtw_pkg

/* logic/gtw_debounce.sv */
`include "gtw_params.svh"
// Qualifies the synchronised external input: one pulse per accepted assertion.
module gtw_debounce
	import gtw_pkg::*;
#(
	parameter int CNT_W = 16,
	parameter int LONG_CYC = `GTW_LONG_CYC
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic act_i,
	input wire logic long_i,
	output logic event_o
);
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic fired_ff;
	logic nxt_fired;
	logic event_ff;
	logic nxt_event;
	logic [CNT_W-1:0] target;

	// Short width is a single clean sample; long width filters switch bounce.
	assign target = long_i ? CNT_W'(LONG_CYC) : CNT_W'(`GTW_SHORT_CYC);

	// Count active cycles; fire once, then wait for the input to drop.
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_fired = fired_ff;
		nxt_event = 1'b0;
		if (!act_i) begin
			nxt_cnt = '0;
			nxt_fired = 1'b0;
		end else if (!fired_ff) begin
			if (cnt_ff + CNT_W'(1) >= target) begin
				nxt_event = 1'b1;
				nxt_fired = 1'b1;
			end else begin
				nxt_cnt = cnt_ff + CNT_W'(1);
			end
		end
	end

	// Register the filter state.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cnt_ff <= '0;
			fired_ff <= 1'b0;
			event_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			fired_ff <= nxt_fired;
			event_ff <= nxt_event;
		end
	end

	assign event_o = event_ff;
endmodule : gtw_debounce

/* logic/gtw_idle_timer.sv */
`include "gtw_params.svh"
// Idle countdown in whole seconds; pulses once when the period runs out.
module gtw_idle_timer
	import gtw_pkg::*;
#(
	parameter int TICK_CYC = `GTW_TICK_CYC
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic reload_i,
	input wire gtw_sel_t sel_i,
	output logic expire_o
);
	logic [23:0] pre_ff;
	logic [23:0] nxt_pre;
	logic [13:0] sec_ff;
	logic [13:0] nxt_sec;
	logic armed_ff;
	logic nxt_armed;
	logic exp_ff;
	logic nxt_exp;

	function automatic logic [13:0] period(input gtw_sel_t s);
		case (s)
			3'h0: period = `GTW_P0;
			3'h1: period = `GTW_P1;
			3'h2: period = `GTW_P2;
			3'h3: period = `GTW_P3;
			3'h4: period = `GTW_P4;
			3'h5: period = `GTW_P5;
			3'h6: period = `GTW_P6;
			default: period = `GTW_P7;
		endcase
	endfunction : period

	// Prescaler and seconds counter; expiry disarms until the next reload.
	always_comb begin
		nxt_pre = pre_ff;
		nxt_sec = sec_ff;
		nxt_armed = armed_ff;
		nxt_exp = 1'b0;
		if (reload_i) begin
			nxt_pre = '0;
			nxt_sec = period(sel_i);
			nxt_armed = 1'b1;
		end else if (armed_ff) begin
			if (pre_ff == 24'(TICK_CYC - 1)) begin
				nxt_pre = '0;
				if (sec_ff <= 14'h1) begin
					nxt_exp = 1'b1;
					nxt_armed = 1'b0;
				end else begin
					nxt_sec = sec_ff - 14'h1;
				end
			end else begin
				nxt_pre = pre_ff + 24'h1;
			end
		end
	end

	// Register counters; after reset the default period runs.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pre_ff <= '0;
			sec_ff <= `GTW_P0;
			armed_ff <= 1'b1;
			exp_ff <= 1'b0;
		end else begin
			pre_ff <= nxt_pre;
			sec_ff <= nxt_sec;
			armed_ff <= nxt_armed;
			exp_ff <= nxt_exp;
		end
	end

	assign expire_o = exp_ff;
endmodule : gtw_idle_timer

/* logic/gtw_top.sv */
// Added by the designer: the AHB-Lite register port.
`include "gtw_params.svh"
// Idle timer and wake-up monitor with an AHB-Lite register slave.
module gtw_top
	import gtw_pkg::*;
#(
	parameter int TICK_CYC = `GTW_TICK_CYC,
	parameter int LONG_CYC = `GTW_LONG_CYC
) (
	input wire logic CLK_I,
	input wire logic SRST_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	input wire logic EXT_MGMT_IN_I,
	input wire logic VEC_ACCESS_I,
	input wire logic [15:0] IRQ_I,
	output logic PERIPH_POWER_EN_O,
	output logic POWER_SAVE_O
);
	// Input synchronisers; the first stage feeds only the second.
	// Nothing else reads a first stage, so a metastable sample settles first.
	// External management input, first and second stage.
	logic ext_s1_ff;
	logic ext_s2_ff;
	// Vector-table access indicator, two stages plus one cycle of history.
	logic vec_s1_ff;
	logic vec_s2_ff;
	logic vec_d_ff;
	// Interrupt lines; the history stage turns a held level into one edge.
	logic [15:0] irq_s1_ff;
	logic [15:0] irq_s2_ff;
	logic [15:0] irq_d_ff;

	// Software registers.
	// Port enable: forced-entry enable, timer enable and plain storage.
	logic [7:0] pen_ff;
	logic [7:0] nxt_pen;
	// Control: vector watch, reload, width, polarity, force and period.
	logic [7:0] ctl_ff;
	logic [7:0] nxt_ctl;
	// Low interrupt enables; unused bits are stored but never acted on.
	logic [7:0] low_ff;
	logic [7:0] nxt_low;
	// High interrupt enables; the reserved bit is stored but ignored.
	logic [7:0] high_ff;
	logic [7:0] nxt_high;

	// Bus data-phase capture.
	// Set for the one data phase that follows a write address phase.
	logic wr_pend_ff;
	logic nxt_wr_pend;
	// Register index taken in the address phase, used in the data phase.
	logic [7:0] wr_idx_ff;
	logic [7:0] nxt_wr_idx;
	// Read data; it stands until the next read address phase.
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;

	// Power state and outputs.
	// Normal or power-saving state of the system.
	gtw_state_e state_ff;
	gtw_state_e nxt_state;
	// Peripheral power enable, active high inside the block.
	logic peripheral_power_enable_ff;
	logic nxt_peripheral_power_enable;
	// Registered copy of the power-saving state for the output pin.
	logic save_ff;
	logic nxt_save;

	// Internal events.
	// External input after polarity, and its qualified event pulse.
	logic ext_act;
	logic ext_ev;
	// Vector access edge and interrupt request edges.
	logic vec_ev;
	logic [15:0] irq_rise;
	logic irq_hit;
	// Any enabled activity, and the same activity while saving power.
	logic activity;
	logic wake;
	// Entry request, timer expiry pulse and forced-entry write.
	logic enter;
	logic expire;
	logic force_wr;
	// Bus address phase qualifier and decoded register index.
	logic addr_ok;
	logic [7:0] addr_idx;

	// Word index decode; only the low index window is mapped.
	// Byte address bits 1:0 are ignored; every transfer is a whole word.
	function automatic logic [7:0] word_idx(input logic [31:0] a);
		word_idx = a[9:2];
	endfunction : word_idx

	// Read value of one register index, taken from next-state values.
	function automatic logic [7:0] reg_read(input logic [7:0] idx, input logic [7:0] pen,
		input logic [7:0] ctl, input logic [7:0] low, input logic [7:0] high,
		input logic normal);
		case (idx)
			`GTW_IDX_PEN: begin
				reg_read = pen;
				reg_read[`GTW_PEN_STATE] = normal;
			end
			`GTW_IDX_CTL: reg_read = ctl;
			`GTW_IDX_LOW: reg_read = low;
			`GTW_IDX_HIGH: reg_read = high;
			// Unmapped indexes read as zero and never raise an error.
			default: reg_read = `GTW_REG_RST;
		endcase
	endfunction : reg_read

	// Two-stage synchronisers for all pin inputs, plus edge history.
	// Reset clears every stage, so a line held high through the release shows one rising edge.
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			ext_s1_ff <= 1'b0;
			ext_s2_ff <= 1'b0;
			vec_s1_ff <= 1'b0;
			vec_s2_ff <= 1'b0;
			vec_d_ff <= 1'b0;
			irq_s1_ff <= '0;
			irq_s2_ff <= '0;
			irq_d_ff <= '0;
		end else begin
			ext_s1_ff <= EXT_MGMT_IN_I;
			ext_s2_ff <= ext_s1_ff;
			vec_s1_ff <= VEC_ACCESS_I;
			vec_s2_ff <= vec_s1_ff;
			vec_d_ff <= vec_s2_ff;
			irq_s1_ff <= IRQ_I;
			irq_s2_ff <= irq_s1_ff;
			irq_d_ff <= irq_s2_ff;
		end
	end

	assign ext_act = ctl_ff[`GTW_CTL_POL] ? ext_s2_ff : ~ext_s2_ff;

	// Width filter for the external management input.
	// Polarity is applied before the filter, so one counter serves both.
	gtw_debounce #(
		.CNT_W(16),
		.LONG_CYC(LONG_CYC)
	) u_debounce (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.act_i(ext_act),
		.long_i(ctl_ff[`GTW_CTL_WID]),
		.event_o(ext_ev)
	);

	assign vec_ev = vec_s2_ff & ~vec_d_ff & ctl_ff[`GTW_CTL_VEC];

	// A request is its rising edge, so a held line counts once.
	assign irq_rise = irq_s2_ff & ~irq_d_ff;

	// low lines; high lines; low bits 2 and 0 and high bit 5 ignored
	assign irq_hit = |(irq_rise[7:0] & low_ff & `GTW_LOW_MASK) |
		|(irq_rise[15:8] & high_ff & `GTW_HIGH_MASK);

	// gated external event; same activity reloads in normal
	assign activity = (ext_ev & ctl_ff[`GTW_CTL_RLD]) | vec_ev | irq_hit;

	// In normal state the same activity only reloads the timer.
	// every wake-up reloads
	assign wake = activity & (state_ff == GTW_SAVE);

	// Idle timer, reloaded by any activity in either state.
	// A period select change takes effect at the next reload.
	gtw_idle_timer #(
		.TICK_CYC(TICK_CYC)
	) u_idle_timer (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.reload_i(activity),
		.sel_i(ctl_ff[`GTW_CTL_SEL_HI:`GTW_CTL_SEL_LO]),
		.expire_o(expire)
	);

	// forced entry on a 1 write
	assign force_wr = wr_pend_ff & (wr_idx_ff == `GTW_IDX_CTL) &
		HWDATA_I[`GTW_CTL_FORCE] & pen_ff[`GTW_PEN_FORCE_EN];

	// Activity in the same cycle blocks an entry request.
	// expiry gated by timer enable
	assign enter = (state_ff == GTW_NORMAL) & ~activity &
		((expire & pen_ff[`GTW_PEN_TMR_EN]) | force_wr);

	// Address phase is valid when selected, non-idle and the bus is ready.
	// Address bits above the register window must be zero.
	assign addr_idx = word_idx(HADDR_I);
	assign addr_ok = HSEL_I & HTRANS_I[1] & HREADY_I & (HADDR_I[31:10] == 22'h0);

	// Bus front end and register writes; a write lands in its data phase.
	always_comb begin
		// A write address phase arms the data-phase capture.
		nxt_wr_pend = addr_ok & HWRITE_I;
		nxt_wr_idx = addr_idx;
		// Registers hold unless the pending write names them.
		nxt_pen = pen_ff;
		nxt_ctl = ctl_ff;
		nxt_low = low_ff;
		nxt_high = high_ff;
		if (wr_pend_ff) begin
			case (wr_idx_ff)
				`GTW_IDX_PEN: nxt_pen = HWDATA_I[7:0];
				`GTW_IDX_CTL: nxt_ctl = HWDATA_I[7:0];
				`GTW_IDX_LOW: nxt_low = HWDATA_I[7:0];
				`GTW_IDX_HIGH: nxt_high = HWDATA_I[7:0];
				// Writes to unmapped indexes change nothing.
				default: nxt_pen = pen_ff;
			endcase
		end
		// The state bit is read-only; it is never stored.
		nxt_pen[`GTW_PEN_STATE] = 1'b0;
		// Reads use next values so a read right after a write sees it.
		nxt_rdata = rdata_ff;
		if (addr_ok & ~HWRITE_I) begin
			nxt_rdata = {24'h0, reg_read(addr_idx, nxt_pen, nxt_ctl, nxt_low,
				nxt_high, nxt_state == GTW_NORMAL)};
		end
	end

	// Power state machine; a wake-up wins over any entry request.
	always_comb begin
		nxt_state = state_ff;
		nxt_peripheral_power_enable = peripheral_power_enable_ff;
		case (state_ff)
			GTW_NORMAL: begin
				// Expiry or a forced write drops peripheral power.
				if (enter) begin
					nxt_state = GTW_SAVE;
					nxt_peripheral_power_enable = 1'b0;
				end
			end
			GTW_SAVE: begin
				if (wake) begin
					nxt_state = GTW_NORMAL;
					nxt_peripheral_power_enable = 1'b1;
				end
			end
			default: begin
				// An illegal state recovers to normal with power on.
				nxt_state = GTW_NORMAL;
				nxt_peripheral_power_enable = 1'b1;
			end
		endcase
		// Registered from the next state, so the pin never glitches.
		nxt_save = (nxt_state == GTW_SAVE);
	end

	// Register all control state; reset leaves the system in normal state.
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			// Registers start at zero, so the shortest period is selected.
			pen_ff <= `GTW_REG_RST;
			ctl_ff <= `GTW_REG_RST;
			low_ff <= `GTW_REG_RST;
			high_ff <= `GTW_REG_RST;
			// No write is pending out of reset.
			wr_pend_ff <= 1'b0;
			wr_idx_ff <= `GTW_REG_RST;
			rdata_ff <= '0;
			// Reset leaves the system normal with peripherals powered.
			state_ff <= GTW_NORMAL;
			peripheral_power_enable_ff <= 1'b1;
			save_ff <= 1'b0;
		end else begin
			// Software registers.
			pen_ff <= nxt_pen;
			ctl_ff <= nxt_ctl;
			low_ff <= nxt_low;
			high_ff <= nxt_high;
			// Bus capture.
			wr_pend_ff <= nxt_wr_pend;
			wr_idx_ff <= nxt_wr_idx;
			rdata_ff <= nxt_rdata;
			// Power state.
			state_ff <= nxt_state;
			peripheral_power_enable_ff <= nxt_peripheral_power_enable;
			save_ff <= nxt_save;
		end
	end

	// Zero wait states and OKAY only; HSIZE is accepted but not checked.
	assign HREADYOUT_O = 1'b1;
	assign HRESP_O = 1'b0;
	// Read data comes straight from its register.
	assign HRDATA_O = rdata_ff;
	// The two power outputs come straight from their flip-flops.
	assign PERIPH_POWER_EN_O = peripheral_power_enable_ff;
	assign POWER_SAVE_O = save_ff;
endmodule : gtw_top

/* tb/gtw_assertions.sv */
// Watches the monitor's pins and bus port from outside.
module gtw_chk #(
	parameter int LONG_CYC = 50000
) (
	input wire logic CLK_I,
	input wire logic SRST_I,
	input wire logic HSEL_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [31:0] HRDATA_O,
	input wire logic HREADYOUT_O,
	input wire logic HRESP_O,
	input wire logic EXT_MGMT_IN_I,
	input wire logic VEC_ACCESS_I,
	input wire logic [15:0] IRQ_I,
	input wire logic PERIPH_POWER_EN_O,
	input wire logic POWER_SAVE_O
);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (SRST_I);
	logic [17:0] pin_ff; // Activity pins one cycle ago.
	logic [17:0] nxt_pin;
	logic [31:0] quiet_ff; // Cycles since an activity pin last moved.
	logic [31:0] nxt_quiet;
	// A wake needs a recent cause; a slow debounce is the longest one.
	always_comb begin
		nxt_pin = {IRQ_I, VEC_ACCESS_I, EXT_MGMT_IN_I};
		nxt_quiet = quiet_ff + 32'h1;
		if (SRST_I || nxt_pin != pin_ff) begin
			nxt_quiet = 32'h0;
		end
	end
	// Registers only.
	always_ff @(posedge CLK_I) begin
		pin_ff <= nxt_pin;
		quiet_ff <= nxt_quiet;
	end
	AST_RST_STATE: assert property (
		$past(SRST_I) |-> !POWER_SAVE_O && PERIPH_POWER_EN_O) else $error("not normal after reset");
	AST_BUS_OKAY: assert property (
		HREADYOUT_O && !HRESP_O) else $error("bus wait or error seen");
	AST_RD_UPPER: assert property (
		HRDATA_O[31:8] == 24'h0) else $error("read data upper bits set");
	AST_RD_HOLD: assert property (
		!$past(HSEL_I && HTRANS_I[1] && !HWRITE_I) |-> $stable(HRDATA_O))
		else $error("read data moved without read");
	AST_SAVE_PWR_OFF: assert property (
		POWER_SAVE_O |-> !PERIPH_POWER_EN_O) else $error("power on in save state");
	AST_WAKE_PWR_ON: assert property (
		$fell(POWER_SAVE_O) |-> ##[0:1] PERIPH_POWER_EN_O) else $error("wake without power");
	AST_WAKE_CAUSE: assert property (
		$fell(POWER_SAVE_O) |-> quiet_ff <= 32'(LONG_CYC + 8)) else $error("wake without cause");
	AST_SAVE_HOLD: assert property (
		POWER_SAVE_O && quiet_ff > 32'(LONG_CYC + 8) |=> POWER_SAVE_O) else $error("left save idle");
endmodule : gtw_chk

bind gtw_top gtw_chk #(.LONG_CYC(LONG_CYC)) u_gtw_chk (.CLK_I(CLK_I), .SRST_I(SRST_I),
	.HSEL_I(HSEL_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HRDATA_O(HRDATA_O),
	.HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .EXT_MGMT_IN_I(EXT_MGMT_IN_I),
	.VEC_ACCESS_I(VEC_ACCESS_I), .IRQ_I(IRQ_I), .PERIPH_POWER_EN_O(PERIPH_POWER_EN_O),
	.POWER_SAVE_O(POWER_SAVE_O));

/* tb/gtw_partner.sv */
// Outside world: interrupt lines, vector accesses and the switch input.
module gtw_partner (
	input wire logic clk_i,
	output logic [15:0] irq_o,
	output logic vec_o,
	output logic ext_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pol = 1'b0; // Active level of the switch input.
	initial begin
		irq_o = 16'h0;
		vec_o = 1'b0;
		ext_o = 1'b1;
	end
	// Settle the idle level so a polarity swap never races a register write.
	task automatic setpol(input logic p);
		@(posedge clk_i);
		pol = p;
		ext_o <= !p;
		repeat (4) @(posedge clk_i);
	endtask : setpol
	task automatic irq(input int n, input int len);
		@(posedge clk_i);
		irq_o[n] <= 1'b1;
		repeat (len) @(posedge clk_i);
		irq_o[n] <= 1'b0;
	endtask : irq
	task automatic vec();
		@(posedge clk_i);
		vec_o <= 1'b1;
		repeat (2) @(posedge clk_i);
		vec_o <= 1'b0;
	endtask : vec
	task automatic ext(input int len);
		@(posedge clk_i);
		ext_o <= pol;
		repeat (len) @(posedge clk_i);
		ext_o <= !pol;
	endtask : ext
endmodule : gtw_partner

/* tb/tb_green_event_timer_wakeup.sv */
`include "gtw_params.svh"
module tb_green_event_timer_wakeup;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TK = 10; // One second shrunk to ten cycles.
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic hrdy;
	logic [15:0] irq;
	logic vec;
	logic ext;
	logic pwr;
	logic ps;
	int bad_count = 0;
	int check_count = 0;
	logic [31:0] d;
	logic [15:0] en;
	int i;
	int n;
	logic [7:0] ec [6] = '{8'h50, 8'h40, 8'h10, 8'h70, 8'h70, 8'h60};
	int el [6] = '{2, 2, 5, 10, 30, 30};
	logic [5:0] ee = 6'b110011;
	always #50 clk = ~clk;
	gtw_top #(.TICK_CYC(TK), .LONG_CYC(20)) u_gtw_top (.CLK_I(clk), .SRST_I(srst),
		.HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
		.HSIZE_I(3'b010), .HWDATA_I(hwdata), .HREADY_I(hrdy), .HRDATA_O(hrdata),
		.HREADYOUT_O(hrdy), .HRESP_O(), .EXT_MGMT_IN_I(ext), .VEC_ACCESS_I(vec),
		.IRQ_I(irq), .PERIPH_POWER_EN_O(pwr), .POWER_SAVE_O(ps));
	gtw_partner u_gtw_partner (.clk_i(clk), .irq_o(irq), .vec_o(vec), .ext_o(ext));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected at %0t: seen %h, expected %h", $time, s, e);
		end
	endtask : chk
	// One single transfer; read data is taken at the edge ending the data phase.
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {22'h0, idx, 2'b00};
		hwrite <= w;
		do @(posedge clk); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, wd};
		do @(posedge clk); while (hrdy !== 1'b1);
		d = hrdata;
	endtask : bus
	task automatic save(input logic [7:0] c);
		bus(1'b1, `GTW_IDX_CTL, c | 8'h08);
		@(posedge clk);
		chk(ps, 1'b1);
	endtask : save
	task automatic waitwake(input logic e);
		for (int k = 0; k < 60 && ps === 1'b1; k++) @(posedge clk);
		chk({ps, pwr}, e ? 2'b01 : 2'b10);
	endtask : waitwake
	function automatic int per_cyc(input int s);
		int t [8] = '{15, 120, 300, 900, 1800, 2700, 3600, 14400};
		return t[s] * TK;
	endfunction : per_cyc
	task automatic end_sim();
		$display("mismatches %0d, checks %0d", bad_count, check_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim
	// A hang costs a mismatch; the tests need under ten thousand cycles.
	initial begin
		repeat (30000) @(posedge clk);
		bad_count++;
		end_sim();
	end
	initial begin
		void'($urandom(84962));
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		// Reset values, then an unmapped hole that reads zero.
		for (i = 0; i < 5; i++) begin
			bus(1'b0, (i == 4) ? 8'hfc : 8'he0 + i[7:0], 8'h00);
			chk(d, (i == 0) ? 32'h8 : 32'h0);
		end
		// bits 2 and 0 of the low enables stay zero.
		for (i = 1; i < 4; i++) begin
			n = $urandom & ((i == 2) ? 32'hf2 : 32'hf7);
			bus(1'b1, 8'he0 + i[7:0], n[7:0]);
			bus(1'b0, 8'he0 + i[7:0], 8'h00);
			chk(d, n);
		end
		bus(1'b1, `GTW_IDX_CTL, 8'h08);
		@(posedge clk);
		chk(ps, 1'b0);
		bus(1'b1, `GTW_IDX_PEN, 8'h01);
		save(8'h00);
		bus(1'b0, `GTW_IDX_PEN, 8'h00);
		chk(d, 32'h1);
		// Every line alone, then every line masked; the enables come from 16'hdefa, which leaves out lines 0, 2, 8 and 13.
		for (i = 0; i < 32; i++) begin
			n = i % 16;
			en = (i < 16) ? (16'hdefa & (16'h1 << n)) : (16'hdefa & ~(16'h1 << n));
			bus(1'b1, `GTW_IDX_LOW, en[7:0]);
			bus(1'b1, `GTW_IDX_HIGH, en[15:8]);
			save(8'h00);
			u_gtw_partner.irq(n, 1 + $urandom % 4);
			waitwake(i < 16 && en != 16'h0);
		end
		for (i = 0; i < 2; i++) begin
			save(i[0] ? 8'h80 : 8'h00);
			u_gtw_partner.vec();
			waitwake(i[0]);
		end
		// Switch input: polarity, pulse width and the reload enable.
		for (i = 0; i < 6; i++) begin
			u_gtw_partner.setpol(ec[i][4]);
			save(ec[i]);
			u_gtw_partner.ext(el[i] + ((el[i] < 5) ? $urandom % 3 : 0));
			waitwake(ee[i]);
		end
		n = $urandom % 2;
		bus(1'b1, `GTW_IDX_CTL, n[7:0]);
		bus(1'b1, `GTW_IDX_LOW, 8'h08);
		bus(1'b1, `GTW_IDX_PEN, 8'h01);
		u_gtw_partner.irq(3, 1);
		repeat (per_cyc(n) + 50) @(posedge clk);
		chk(ps, 1'b0);
		bus(1'b1, `GTW_IDX_PEN, 8'h04);
		u_gtw_partner.irq(3, 1);
		repeat (per_cyc(n) / 2) @(posedge clk);
		u_gtw_partner.irq(3, 1);
		chk(ps, 1'b0);
		repeat (per_cyc(n) - 25) @(posedge clk);
		chk(ps, 1'b0);
		for (i = 0; i < 60 && ps !== 1'b1; i++) @(posedge clk);
		chk({ps, pwr}, 2'b10);
		end_sim();
	end
endmodule : tb_green_event_timer_wakeup
